// [rtl/lcp_pkg.sv]
// constants for the cell protector register bank
package lcp_pkg;
    localparam logic [7:0] LCP_OFS_PROT = 8'h00;
    localparam logic [7:0] LCP_OFS_STAT = 8'h01;
    localparam logic [7:0] LCP_OFS_NVCL = 8'h07;
    localparam logic [7:0] LCP_OFS_SWHT = 8'h08;
    localparam logic [7:0] LCP_EE_DEFAULTS = 8'h31;
    localparam logic [7:0] LCP_EE_B0_LO = 8'h20;
    localparam logic [7:0] LCP_EE_B0_HI = 8'h23;
    localparam logic [7:0] LCP_EE_B1_LO = 8'h30;
    localparam logic [7:0] LCP_EE_B1_HI = 8'h33;
    localparam logic [7:0] LCP_OP_ID_A = 8'h33;
    localparam logic [7:0] LCP_OP_ID_B = 8'h39;
    localparam int LCP_B_HIGH = 7;
    localparam int LCP_B_LOW = 6;
    localparam int LCP_B_ZERO = 5;
    localparam int LCP_B_EXC = 4;
    localparam int LCP_B_CMIR = 3;
    localparam int LCP_B_DMIR = 2;
    localparam int LCP_B_CALW = 1;
    localparam int LCP_B_DALW = 0;
    localparam int LCP_B_IDSEL = 4;
    localparam logic [7:0] LCP_STAT_MASK = 8'h10;
    localparam int LCP_B_COPY = 7;
    localparam int LCP_B_LKEN = 6;
    localparam int LCP_B_BL1 = 1;
    localparam int LCP_B_BL0 = 0;
    localparam int LCP_B_SWF = 7;
    localparam int LCP_B_HEAT = 0;
    localparam logic LCP_RST_HIGH = 1'b0;
    localparam logic LCP_RST_LOW = 1'b1;
    localparam logic LCP_RST_EXC = 1'b1;
    localparam logic LCP_RST_ALW = 1'b1;
    localparam logic LCP_RST_LKEN = 1'b0;
    localparam logic LCP_RST_SWF = 1'b1;
    localparam logic LCP_RST_HEAT = 1'b0;
    localparam logic LCP_RST_IDSEL = 1'b0;
endpackage

// [rtl/lcp_regs.sv]
// register bank of the single-cell protector
//
// Functional notes
// - overvoltage sets high_cell_flag; host clears; reset 0
// - undervoltage sets low_cell_flag; reset 1
// - overcurrent sets excess_current_flag; reset 1
// - bit 3 mirrors charge gate
// - bit 2 mirrors discharge gate
// - charge_allow 0 forces charge gate low
// - discharge_allow 0 forces discharge gate low
// - wake sets both allows; reset 1
// - block 1 recall loads status register
// - id select bit picks 33h or 39h
// - copy active bit blocks nv writes
// - nv writes need idle, unlocked, active
// - lock needs enable; enable clears after lock
// - block1_locked shows block 1 lock
// - block0_locked shows block 0 lock
// - switch pin low clears flag; host rearms
// - heat fault holds both gates off
// - host write 1 to heat flag disables
// - protection flags stick until host clears
// - copy only unlocked; recall always
module lcp_regs
    import lcp_pkg::*;
#(
    parameter int COPY_CYCLES = 100
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_nv_wr_ok,
    input wire logic i_copy_cmd,
    input wire logic i_recall_cmd,
    input wire logic i_lock_cmd,
    input wire logic i_cmd_block,
    input wire logic [7:0] i_recall_defaults,
    output logic o_copy_start,
    output logic o_copy_block,
    input wire logic i_ov_det,
    input wire logic i_uv_det,
    input wire logic i_oc_det,
    input wire logic i_ot_det,
    input wire logic i_cv_block,
    input wire logic i_dv_block,
    input wire logic i_active,
    input wire logic i_switch_pin_n,
    output logic o_charge_gate,
    output logic o_discharge_gate,
    output logic [7:0] o_id_opcode,
    output logic o_block0_locked,
    output logic o_block1_locked
);
    // copy counter is 16 bits wide
    if (COPY_CYCLES < 1 || COPY_CYCLES > 65535)
    begin : g_bad_copy_cycles
        $error("COPY_CYCLES out of range");
    end

    typedef struct packed {
        logic high_cell_flag;
        logic low_cell_flag;
        logic excess_current_flag;
        logic charge_allow;
        logic discharge_allow;
        logic id_read_opcode_sel;
        logic nv_copy_active;
        logic [15:0] copy_cnt;
        logic lock_enable;
        logic block1_locked;
        logic block0_locked;
        logic switch_pin_flag;
        logic heat_fault_flag;
        logic [2:0] sw_sync;
        logic sw_low;
        logic [2:0] act_sync;
        logic act;
        logic charge_gate;
        logic discharge_gate;
        logic [7:0] rdata;
        logic nv_wr_ok;
        logic copy_start;
        logic copy_block;
        logic [7:0] id_opcode;
    } lcp_state_t;

    lcp_state_t s_q;
    lcp_state_t s_d;
    logic [7:0] prot_rd;
    logic [7:0] nvcl_rd;
    logic [7:0] swht_rd;
    logic in_b0;
    logic in_b1;

    always_comb
    begin
        // bit 5 reads as zero, reserved bits zero
        prot_rd = 8'h00;
        prot_rd[LCP_B_HIGH] = s_q.high_cell_flag;
        prot_rd[LCP_B_LOW] = s_q.low_cell_flag;
        prot_rd[LCP_B_EXC] = s_q.excess_current_flag;
        prot_rd[LCP_B_CMIR] = s_q.charge_gate;
        prot_rd[LCP_B_DMIR] = s_q.discharge_gate;
        prot_rd[LCP_B_CALW] = s_q.charge_allow;
        prot_rd[LCP_B_DALW] = s_q.discharge_allow;
        nvcl_rd = 8'h00;
        nvcl_rd[LCP_B_COPY] = s_q.nv_copy_active;
        nvcl_rd[LCP_B_LKEN] = s_q.lock_enable;
        nvcl_rd[LCP_B_BL1] = s_q.block1_locked;
        nvcl_rd[LCP_B_BL0] = s_q.block0_locked;
        swht_rd = 8'h00;
        swht_rd[LCP_B_SWF] = s_q.switch_pin_flag;
        swht_rd[LCP_B_HEAT] = s_q.heat_fault_flag;
        // nv block windows on the raw address
        in_b0 = (i_addr >= LCP_EE_B0_LO) && (i_addr <= LCP_EE_B0_HI);
        in_b1 = (i_addr >= LCP_EE_B1_LO) && (i_addr <= LCP_EE_B1_HI);
    end

    always_comb
    begin
        s_d = s_q;
        // pin and mode inputs: three stages, second and third agree
        s_d.sw_sync = {s_q.sw_sync[1:0], i_switch_pin_n};
        if (s_q.sw_sync[2] == s_q.sw_sync[1])
        begin
            s_d.sw_low = ~s_q.sw_sync[2];
        end
        s_d.act_sync = {s_q.act_sync[1:0], i_active};
        if (s_q.act_sync[2] == s_q.act_sync[1])
        begin
            s_d.act = s_q.act_sync[2];
        end

        // host writes; hardware sets below win over clears
        if (i_wr)
        begin
            unique case (i_addr)
                LCP_OFS_PROT:
                begin
                    s_d.high_cell_flag = i_wdata[LCP_B_HIGH];
                    s_d.low_cell_flag = i_wdata[LCP_B_LOW];
                    s_d.excess_current_flag = i_wdata[LCP_B_EXC];
                    s_d.charge_allow = i_wdata[LCP_B_CALW];
                    s_d.discharge_allow = i_wdata[LCP_B_DALW];
                end
                LCP_OFS_NVCL:
                begin
                    s_d.lock_enable = i_wdata[LCP_B_LKEN];
                end
                LCP_OFS_SWHT:
                begin
                    s_d.switch_pin_flag = i_wdata[LCP_B_SWF];
                    s_d.heat_fault_flag = i_wdata[LCP_B_HEAT];
                end
                default:
                begin
                end
            endcase
        end

        if (i_ov_det)
        begin
            s_d.high_cell_flag = 1'b1;
        end
        if (i_uv_det)
        begin
            s_d.low_cell_flag = 1'b1;
        end
        if (i_oc_det)
        begin
            s_d.excess_current_flag = 1'b1;
        end
        if (i_ot_det)
        begin
            s_d.heat_fault_flag = 1'b1;
        end
        // after host writes, so a held-low pin beats a rearm
        // switch pin low clears flag
        if (s_q.sw_low)
        begin
            s_d.switch_pin_flag = 1'b0;
        end
        // wake edge on synced level; act resets high, no false edge
        // sleep to active sets allows
        if (s_d.act && !s_q.act)
        begin
            s_d.charge_allow = 1'b1;
            s_d.discharge_allow = 1'b1;
        end

        if (i_recall_cmd && i_cmd_block)
        begin
            s_d.id_read_opcode_sel = i_recall_defaults[LCP_B_IDSEL];
        end

        // busy for COPY_CYCLES cycles; copy while busy is ignored
        s_d.copy_start = 1'b0;
        if (i_copy_cmd && !s_q.nv_copy_active)
        begin
            if (i_cmd_block ? !s_q.block1_locked : !s_q.block0_locked)
            begin
                s_d.nv_copy_active = 1'b1;
                s_d.copy_cnt = 16'(COPY_CYCLES - 1);
                s_d.copy_start = 1'b1;
                s_d.copy_block = i_cmd_block;
            end
        end
        else if (s_q.nv_copy_active)
        begin
            if (s_q.copy_cnt == 16'h0000)
            begin
                s_d.nv_copy_active = 1'b0;
            end
            else
            begin
                s_d.copy_cnt = s_q.copy_cnt - 16'h0001;
            end
        end

        // lock only when enabled, then clear
        if (i_lock_cmd && s_q.lock_enable)
        begin
            if (i_cmd_block)
            begin
                s_d.block1_locked = 1'b1;
            end
            else
            begin
                s_d.block0_locked = 1'b1;
            end
            s_d.lock_enable = 1'b0;
        end

        // accept pulse stands one cycle after the write
        // nv write acceptance
        s_d.nv_wr_ok = i_wr && !s_q.nv_copy_active && s_q.act
            && ((in_b0 && !s_q.block0_locked)
            || (in_b1 && !s_q.block1_locked));

        // gates lag the allow and heat registers by one cycle
        // charge gate forced low when disallowed
        s_d.charge_gate = s_q.charge_allow && !i_cv_block
            && !s_q.heat_fault_flag;
        // discharge gate forced low when disallowed
        s_d.discharge_gate = s_q.discharge_allow && !i_dv_block
            && !s_q.heat_fault_flag;

        if (s_q.id_read_opcode_sel)
        begin
            s_d.id_opcode = LCP_OP_ID_B;
        end
        else
        begin
            s_d.id_opcode = LCP_OP_ID_A;
        end

        s_d.rdata = 8'h00;
        if (i_rd)
        begin
            unique case (i_addr)
                LCP_OFS_PROT:
                begin
                    s_d.rdata = prot_rd;
                end
                // status bits 5 and 3 read zero
                LCP_OFS_STAT:
                begin
                    s_d.rdata = {3'h0, s_q.id_read_opcode_sel, 4'h0};
                end
                LCP_OFS_NVCL:
                begin
                    s_d.rdata = nvcl_rd;
                end
                LCP_OFS_SWHT:
                begin
                    s_d.rdata = swht_rd;
                end
                default:
                begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            s_q <= '0;
            s_q.high_cell_flag <= LCP_RST_HIGH;
            s_q.low_cell_flag <= LCP_RST_LOW;
            s_q.excess_current_flag <= LCP_RST_EXC;
            s_q.charge_allow <= LCP_RST_ALW;
            s_q.discharge_allow <= LCP_RST_ALW;
            s_q.lock_enable <= LCP_RST_LKEN;
            s_q.switch_pin_flag <= LCP_RST_SWF;
            s_q.heat_fault_flag <= LCP_RST_HEAT;
            s_q.id_read_opcode_sel <= LCP_RST_IDSEL;
            // synchronisers start at the idle pin levels
            s_q.sw_sync <= 3'h7;
            s_q.act_sync <= 3'h7;
            s_q.act <= 1'b1;
            s_q.id_opcode <= LCP_OP_ID_A;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_nv_wr_ok = s_q.nv_wr_ok;
    assign o_copy_start = s_q.copy_start;
    assign o_copy_block = s_q.copy_block;
    assign o_charge_gate = s_q.charge_gate;
    assign o_discharge_gate = s_q.discharge_gate;
    assign o_id_opcode = s_q.id_opcode;
    assign o_block0_locked = s_q.block0_locked;
    assign o_block1_locked = s_q.block1_locked;
endmodule

// [testbench/lcp_host.sv]
// behavioural host master driving the register strobes
module lcp_host
(
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    input wire logic i_nv_wr_ok,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic acc(input logic w, input logic [7:0] a, d,
        output logic [7:0] q);
        @(negedge i_clk_sys);
        o_wr = w;
        o_rd = ~w;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk_sys);
        q = w ? {7'h00, i_nv_wr_ok} : i_rdata;
        o_wr = 1'b0;
        o_rd = 1'b0;
        // released bus shows inverted values
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule

// [testbench/lcp_regs_chk.sv]
// port assertions for the cell protector register bank
module lcp_regs_chk
    import lcp_pkg::*;
#(
    parameter int COPY_CYCLES = 100
)
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_nv_wr_ok,
    input wire logic i_recall_cmd,
    input wire logic i_cmd_block,
    input wire logic [7:0] i_recall_defaults,
    input wire logic o_copy_start,
    input wire logic i_ot_det,
    input wire logic o_charge_gate,
    input wire logic o_discharge_gate,
    input wire logic [7:0] o_id_opcode,
    input wire logic o_block0_locked,
    input wire logic o_block1_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    logic nv0, nv1, nv_open;
    assign nv0 = i_addr >= LCP_EE_B0_LO && i_addr <= LCP_EE_B0_HI;
    assign nv1 = i_addr >= LCP_EE_B1_LO && i_addr <= LCP_EE_B1_HI;
    assign nv_open = i_wr
        && (nv0 && !o_block0_locked || nv1 && !o_block1_locked);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    property p_mirror;
        i_rd && i_addr == LCP_OFS_PROT |=> !o_rdata[LCP_B_ZERO] &&
            o_rdata[3:2] == $past({o_charge_gate, o_discharge_gate});
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("gate mirror bits wrong");
    property p_stat;
        i_rd && i_addr == LCP_OFS_STAT
            |=> (o_rdata & ~LCP_STAT_MASK) == 8'h00;
    endproperty
    a_stat: assert property (p_stat)
        else $error("status fixed bits wrong");
    property p_calw;
        i_wr && i_addr == LCP_OFS_PROT && !i_wdata[LCP_B_CALW]
            |-> ##2 !o_charge_gate;
    endproperty
    a_calw: assert property (p_calw)
        else $error("charge gate not forced low");
    property p_dalw;
        i_wr && i_addr == LCP_OFS_PROT && !i_wdata[LCP_B_DALW]
            |-> ##2 !o_discharge_gate;
    endproperty
    a_dalw: assert property (p_dalw)
        else $error("discharge gate not forced low");
    property p_heat;
        i_ot_det |-> ##2 !o_charge_gate && !o_discharge_gate;
    endproperty
    a_heat: assert property (p_heat)
        else $error("gates on during heat fault");
    property p_nvok;
        o_nv_wr_ok |-> $past(nv_open);
    endproperty
    a_nvok: assert property (p_nvok)
        else $error("nv write accepted wrongly");
    property p_copy_busy;
        o_copy_start ##[0:3] nv_open |=> !o_nv_wr_ok;
    endproperty
    a_copy_busy: assert property (p_copy_busy)
        else $error("nv write accepted during copy");
    property p_opc;
        i_recall_cmd && i_cmd_block |-> ##2 o_id_opcode ==
            (i_recall_defaults[LCP_B_IDSEL] ? LCP_OP_ID_B : LCP_OP_ID_A);
    endproperty
    a_opc: assert property (p_opc)
        else $error("id opcode wrong after recall");
endmodule
bind lcp_regs lcp_regs_chk #(.COPY_CYCLES(COPY_CYCLES)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_nv_wr_ok(o_nv_wr_ok), .i_recall_cmd(i_recall_cmd),
    .i_cmd_block(i_cmd_block), .i_recall_defaults(i_recall_defaults),
    .o_copy_start(o_copy_start), .i_ot_det(i_ot_det),
    .o_charge_gate(o_charge_gate), .o_discharge_gate(o_discharge_gate),
    .o_id_opcode(o_id_opcode), .o_block0_locked(o_block0_locked),
    .o_block1_locked(o_block1_locked));

// [testbench/testbench.sv]
// self-checking bench for the cell protector register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lcp_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_wr, i_rd, o_nv_wr_ok, o_copy_start, o_copy_block;
    logic [7:0] i_addr, i_wdata, o_rdata, o_id_opcode, q, w;
    logic [7:0] i_recall_defaults = 8'h00;
    logic i_copy_cmd = 0, i_recall_cmd = 0, i_lock_cmd = 0, i_cmd_block = 0;
    logic i_ov_det = 0, i_uv_det = 0, i_oc_det = 0, i_ot_det = 0;
    logic i_cv_block = 0, i_dv_block = 0, i_active = 1, i_switch_pin_n = 1;
    logic o_charge_gate, o_discharge_gate, o_block0_locked, o_block1_locked;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    lcp_regs #(.COPY_CYCLES(4)) dut (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wr(i_wr),
        .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_nv_wr_ok(o_nv_wr_ok),
        .i_copy_cmd(i_copy_cmd), .i_recall_cmd(i_recall_cmd),
        .i_lock_cmd(i_lock_cmd), .i_cmd_block(i_cmd_block),
        .i_recall_defaults(i_recall_defaults),
        .o_copy_start(o_copy_start), .o_copy_block(o_copy_block),
        .i_ov_det(i_ov_det), .i_uv_det(i_uv_det), .i_oc_det(i_oc_det),
        .i_ot_det(i_ot_det), .i_cv_block(i_cv_block),
        .i_dv_block(i_dv_block), .i_active(i_active),
        .i_switch_pin_n(i_switch_pin_n), .o_charge_gate(o_charge_gate),
        .o_discharge_gate(o_discharge_gate), .o_id_opcode(o_id_opcode),
        .o_block0_locked(o_block0_locked),
        .o_block1_locked(o_block1_locked));
    lcp_host host (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata),
        .i_nv_wr_ok(o_nv_wr_ok), .o_wr(i_wr), .o_rd(i_rd),
        .o_addr(i_addr), .o_wdata(i_wdata));
    task automatic chk(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, exp);
        host.acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, d);
        host.acc(1'b1, a, d, q);
    endtask
    task automatic pls(ref logic s);
        @(negedge i_clk_sys);
        s = 1'b1;
        @(negedge i_clk_sys);
        s = 1'b0;
        repeat (4) @(negedge i_clk_sys);
    endtask
    function automatic logic [7:0] pexp(logic [7:0] d, logic cb, db);
        return {d[7:6], 1'b0, d[4], d[1] & ~cb, d[0] & ~db, d[1:0]};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #800us;
        n_mismatch++;
        test_done();
    end
    initial
    begin
        void'($urandom(90));
        repeat (4) @(negedge i_clk_sys);
        i_reset = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        rd(LCP_OFS_PROT, 8'h5f);
        rd(LCP_OFS_STAT, 8'h00);
        rd(LCP_OFS_NVCL, 8'h00);
        rd(LCP_OFS_SWHT, 8'h80);
        chk(o_id_opcode, LCP_OP_ID_A);
        $display("test reset done");
        for (int k = 0; k < 10; k++)
        begin
            w = k < 2 ? {8{k[0]}} : 8'($urandom());
            {i_cv_block, i_dv_block} = 2'($urandom());
            wr(LCP_OFS_PROT, w);
            repeat (3) @(negedge i_clk_sys);
            w = pexp(w, i_cv_block, i_dv_block);
            rd(LCP_OFS_PROT, w);
            q = {6'h00, o_charge_gate, o_discharge_gate};
            chk(q, {6'h00, w[3:2]});
        end
        {i_cv_block, i_dv_block} = 2'b00;
        wr(LCP_OFS_PROT, 8'h03);
        pls(i_ov_det);
        rd(LCP_OFS_PROT, 8'h8f);
        pls(i_uv_det);
        rd(LCP_OFS_PROT, 8'hcf);
        pls(i_oc_det);
        rd(LCP_OFS_PROT, 8'hdf);
        // detectors quiet before the host clears
        wr(LCP_OFS_PROT, 8'h03);
        rd(LCP_OFS_PROT, 8'h0f);
        pls(i_ot_det);
        rd(LCP_OFS_SWHT, 8'h81);
        rd(LCP_OFS_PROT, 8'h03);
        wr(LCP_OFS_SWHT, 8'h80);
        repeat (3) @(negedge i_clk_sys);
        rd(LCP_OFS_PROT, 8'h0f);
        wr(LCP_OFS_SWHT, 8'hff);
        rd(LCP_OFS_SWHT, 8'h81);
        rd(LCP_OFS_PROT, 8'h03);
        wr(LCP_OFS_SWHT, 8'h80);
        $display("test flags done");
        i_switch_pin_n = 1'b0;
        repeat (6) @(negedge i_clk_sys);
        i_switch_pin_n = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        rd(LCP_OFS_SWHT, 8'h00);
        wr(LCP_OFS_SWHT, 8'h80);
        rd(LCP_OFS_SWHT, 8'h80);
        wr(LCP_OFS_STAT, 8'hff);
        rd(LCP_OFS_STAT, 8'h00);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        wr(LCP_OFS_PROT, 8'h00);
        i_active = 1'b0;
        repeat (6) @(negedge i_clk_sys);
        wr(LCP_EE_B0_LO, 8'h5a);
        chk(q, 8'h00);
        i_active = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        rd(LCP_OFS_PROT, 8'h0f);
        $display("test wake done");
        wr(LCP_EE_B0_LO, 8'h5a);
        chk(q, 8'h01);
        wr(LCP_OFS_NVCL, 8'h40);
        rd(LCP_OFS_NVCL, 8'h40);
        pls(i_lock_cmd);
        rd(LCP_OFS_NVCL, 8'h01);
        chk({6'h00, o_block1_locked, o_block0_locked}, 8'h01);
        wr(LCP_EE_B0_HI, 8'h11);
        chk(q, 8'h00);
        i_cmd_block = 1'b1;
        pls(i_lock_cmd);
        rd(LCP_OFS_NVCL, 8'h01);
        @(negedge i_clk_sys);
        i_copy_cmd = 1'b1;
        @(negedge i_clk_sys);
        i_copy_cmd = 1'b0;
        chk({6'h00, o_copy_start, o_copy_block}, 8'h03);
        rd(LCP_OFS_NVCL, 8'h81);
        wr(LCP_EE_B1_LO, 8'h22);
        chk(q, 8'h00);
        repeat (6) @(negedge i_clk_sys);
        rd(LCP_OFS_NVCL, 8'h01);
        i_cmd_block = 1'b0;
        @(negedge i_clk_sys);
        i_copy_cmd = 1'b1;
        @(negedge i_clk_sys);
        i_copy_cmd = 1'b0;
        chk(8'(o_copy_start), 8'h00);
        rd(LCP_OFS_NVCL, 8'h01);
        $display("test nv done");
        wr(LCP_OFS_NVCL, 8'h40);
        i_cmd_block = 1'b1;
        pls(i_lock_cmd);
        rd(LCP_OFS_NVCL, 8'h03);
        chk({6'h00, o_block1_locked, o_block0_locked}, 8'h03);
        for (int k = 0; k < 4; k++)
        begin
            i_recall_defaults = k == 0 ? 8'hff : 8'($urandom());
            pls(i_recall_cmd);
            w = i_recall_defaults & LCP_STAT_MASK;
            rd(LCP_OFS_STAT, w);
            w = i_recall_defaults[4] ? LCP_OP_ID_B : LCP_OP_ID_A;
            chk(o_id_opcode, w);
        end
        // a block 0 recall leaves the status register alone
        i_cmd_block = 1'b0;
        i_recall_defaults = ~i_recall_defaults;
        pls(i_recall_cmd);
        rd(LCP_OFS_STAT, ~i_recall_defaults & LCP_STAT_MASK);
        $display("test recall done");
        test_done();
    end
endmodule
